// ===== hw/watchdog_timer.sv
// watchdog timer with prescaler, postscaler, window mode and apb registers
// assumes rc_tick_async is a slow rc clock from another domain; other inputs on pclk
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "wdt_params.svh"

module watchdog_timer (
	// clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               clk_en,
	// apb
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [11:0]        paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	// core events
	input  wire logic               rc_tick_async,
	input  wire logic               clear_watchdog_instr,
	input  wire logic               power_save_instr,
	input  wire logic               power_save_idle,
	input  wire logic               wake_other,
	input  wire logic               clock_switch_done,
	// outputs
	output logic                    watchdog_reset,
	output logic                    wake_core,
	output logic                    low_power_rc_osc_en,
	output wdt_pkg::power_type      power_state,
	output logic                    irq
);
	import wdt_pkg::*;

	logic [7:0]              config_word;
	logic                    soft_enable_bit;
	logic                    timeout_flag;
	logic                    sleep_status;
	logic                    idle_status;
	logic [`IRQ_WIDTH-1:0]   irq_status;
	logic [`IRQ_WIDTH-1:0]   irq_mask;
	logic [6:0]              pre_count;
	logic [14:0]             post_count;
	logic                    rc_sync1;
	logic                    rc_sync2;
	logic                    rc_prev;
	logic [3:0]              rst_cnt;
	logic                    enabled;
	logic                    rc_edge;
	logic                    pre_done;
	logic                    post_done;
	logic                    timeout;
	logic                    early_clear;
	logic                    wake_exit;
	logic                    counts_clear;
	logic [14:0]             post_limit;
	logic                    apb_acc;
	logic                    apb_wr;
	logic                    apb_rd;
	logic                    addr_ok;
	logic [`IRQ_WIDTH-1:0]   events;
	logic [24:0]             elapsed_x4;
	logic [24:0]             limit_x3;
	logic [24:0]             period_x3;

	function automatic logic [14:0] ratio_limit(input logic [3:0] code);
		ratio_limit = 15'((32'h1 << code) - 32'h1);
	endfunction : ratio_limit

	function automatic logic is_mapped(input logic [11:0] a);
		is_mapped = (a == `OFS_CONFIG) || (a == `OFS_CONTROL) || (a == `OFS_STATUS)
			|| (a == `OFS_IRQ_STATUS) || (a == `OFS_IRQ_MASK) || (a == `OFS_COUNT);
	endfunction : is_mapped

	assign enabled      = config_word[`CFG_FUSE_BIT] | soft_enable_bit;
	assign rc_edge      = rc_sync2 & ~rc_prev;
	assign pre_done     = rc_edge && (pre_count == (config_word[`CFG_PRE_BIT] ?
		`PRE_LONG : `PRE_SHORT));
	assign post_limit   = ratio_limit(config_word[`CFG_POST_MSB:`CFG_POST_LSB]);
	assign post_done    = pre_done && (post_count == post_limit);
	assign timeout      = enabled && post_done;
	// elapsed slow edges times four against three times the whole period
	assign elapsed_x4   = config_word[`CFG_PRE_BIT] ?
		({10'h000, post_count} << 9) + {16'h0000, pre_count, 2'b00} :
		({10'h000, post_count} << 7) + {16'h0000, pre_count, 2'b00};
	assign limit_x3     = {9'h000, post_limit, 1'b0} + {10'h000, post_limit} + 25'h0000003;
	assign period_x3    = config_word[`CFG_PRE_BIT] ? (limit_x3 << 7) : (limit_x3 << 5);
	// window open only in the last quarter of the postscaled period
	assign early_clear  = enabled && !config_word[`CFG_WINDOW_DISABLE_BIT]
		&& clear_watchdog_instr && (power_state == run_mode)
		&& (elapsed_x4 < period_x3);
	assign wake_exit    = (power_state != run_mode) && (wake_other || timeout);
	assign counts_clear = clock_switch_done || power_save_instr || wake_exit
		|| (clear_watchdog_instr && power_state == run_mode);
	assign apb_acc      = psel && penable && pready;
	assign addr_ok      = is_mapped(paddr);
	assign apb_wr       = apb_acc && pwrite && addr_ok;
	assign apb_rd       = apb_acc && !pwrite && addr_ok;
	assign events       = {early_clear, wake_exit && timeout, timeout};

	// rc clock synchroniser
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rc_sync1 <= 1'b0;
			rc_sync2 <= 1'b0;
			rc_prev  <= 1'b0;
		end else if (clk_en) begin
			rc_sync1 <= rc_tick_async;
			rc_sync2 <= rc_sync1;
			rc_prev  <= rc_sync2;
		end
	end

	// prescaler and postscaler
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_count  <= 7'h00;
			post_count <= 15'h0000;
		end else if (clk_en) begin
			if (counts_clear || !enabled) begin
				pre_count  <= 7'h00;
				post_count <= 15'h0000;
			end else if (rc_edge) begin
				if (pre_done) begin
					pre_count  <= 7'h00;
					post_count <= post_done ? 15'h0000 : post_count + 15'h0001;
				end else begin
					pre_count <= pre_count + 7'h01;
				end
			end
		end
	end

	// power state tracking
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_state <= run_mode;
		end else if (clk_en) begin
			if (wake_exit) begin
				power_state <= run_mode;
			end else if (power_save_instr && power_state == run_mode) begin
				power_state <= power_save_idle ? idle_mode : sleep_mode;
			end
		end
	end

	// outputs toward the core
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_core           <= 1'b0;
			low_power_rc_osc_en <= 1'b0;
		end else if (clk_en) begin
			wake_core           <= wake_exit && timeout;
			low_power_rc_osc_en <= enabled;
		end
	end

	// reset pulse on run-mode timeout or early clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_cnt        <= 4'h0;
			watchdog_reset <= 1'b0;
		end else if (clk_en) begin
			if ((timeout && power_state == run_mode) || early_clear) begin
				rst_cnt        <= 4'(`RESET_PULSE_CYC);
				watchdog_reset <= 1'b1;
			end else if (rst_cnt > 4'h1) begin
				rst_cnt <= rst_cnt - 4'h1;
			end else begin
				rst_cnt        <= 4'h0;
				watchdog_reset <= 1'b0;
			end
		end
	end

	// configuration word, soft enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			config_word     <= `CFG_RESET;
			soft_enable_bit <= 1'b0;
		end else if (clk_en && apb_wr) begin
			if (paddr == `OFS_CONFIG) begin
				config_word <= pwdata[7:0];
			end
			if (paddr == `OFS_CONTROL) begin
				soft_enable_bit <= pwdata[`CTL_SOFT_BIT];
			end
		end
	end

	// sticky status bits: hardware set wins over software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timeout_flag <= 1'b0;
			sleep_status <= 1'b0;
			idle_status  <= 1'b0;
		end else if (clk_en) begin
			if (apb_wr && paddr == `OFS_CONTROL) begin
				timeout_flag <= pwdata[`CTL_FLAG_BIT] & timeout_flag;
				sleep_status <= pwdata[`CTL_SLEEP_BIT] & sleep_status;
				idle_status  <= pwdata[`CTL_IDLE_BIT] & idle_status;
			end
			if (timeout) begin
				timeout_flag <= 1'b1;
			end
			if (power_save_instr && power_state == run_mode) begin
				if (power_save_idle) begin
					idle_status <= 1'b1;
				end else begin
					sleep_status <= 1'b1;
				end
			end
		end
	end

	// interrupt status, cleared by read, set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= '0;
			irq_mask   <= '0;
			irq        <= 1'b0;
		end else if (clk_en) begin
			if (apb_rd && paddr == `OFS_IRQ_STATUS) begin
				irq_status <= events;
			end else begin
				irq_status <= irq_status | events;
			end
			if (apb_wr && paddr == `OFS_IRQ_MASK) begin
				irq_mask <= pwdata[`IRQ_WIDTH-1:0];
			end
			irq <= |((irq_status | events) & irq_mask);
		end
	end

	// apb response, no wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (clk_en) begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !addr_ok;
			prdata  <= 32'h0000_0000;
			if (psel && !penable && !pwrite) begin
				unique case (paddr)
					`OFS_CONFIG:     prdata <= {24'h000000, config_word};
					`OFS_CONTROL:    prdata <= {26'h0, soft_enable_bit, timeout_flag,
						sleep_status, idle_status, 2'b00};
					`OFS_STATUS:     prdata <= {29'h0, enabled, 2'(power_state)};
					`OFS_IRQ_STATUS: prdata <= {29'h0, irq_status};
					`OFS_IRQ_MASK:   prdata <= {29'h0, irq_mask};
					`OFS_COUNT:      prdata <= {10'h000, post_count, pre_count};
					default:         prdata <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule : watchdog_timer

// ===== hw/wdt_params.svh
// watchdog constants: register offsets, field positions, reset values, timing counts
// assumes an apb slave on pclk at 100 MHz and a slow rc tick from a pin
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

`define OFS_CONFIG      12'h000
`define OFS_CONTROL     12'h004
`define OFS_STATUS      12'h008
`define OFS_IRQ_STATUS  12'h00c
`define OFS_IRQ_MASK    12'h010
`define OFS_COUNT       12'h014

// config word fields
`define CFG_POST_LSB    0
`define CFG_POST_MSB    3
`define CFG_PRE_BIT     4
`define CFG_WINDOW_DISABLE_BIT  6
`define CFG_FUSE_BIT    7
`define CFG_RESET       8'hdf

// control/status register fields
`define CTL_IDLE_BIT    2
`define CTL_SLEEP_BIT   3
`define CTL_FLAG_BIT    4
`define CTL_SOFT_BIT    5

// interrupt status bits
`define IRQ_TIMEOUT     0
`define IRQ_WAKE        1
`define IRQ_WIN_ERR     2
`define IRQ_WIDTH       3

`define PRE_SHORT       7'h1f
`define PRE_LONG        7'h7f
`define RC_KHZ          32
`define RESET_PULSE_NS  100
`define RESET_PULSE_CYC ((`RESET_PULSE_NS + 9) / 10)

`endif

// ===== hw/wdt_pkg.sv
// watchdog types shared between design and bench
// assumes nothing beyond the parameter header
package wdt_pkg;
	typedef enum logic [1:0] {
		run_mode,
		sleep_mode,
		idle_mode
	} power_type;
endpackage : wdt_pkg

// ===== tb/test_watchdog_timer_window_mode.sv
// self-checking bench for the watchdog timer
// assumes a free slow rc clock driven here, unrelated to pclk
`timescale 1ns/1ns
module test_watchdog_timer_window_mode;
	import wdt_pkg::*;
	logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0, err;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, watchdog_reset, wake_core, low_power_rc_osc_en, irq;
	logic rc_tick_async = 0, clear_watchdog_instr = 0, power_save_instr = 0;
	logic power_save_idle = 0, wake_other = 0, clock_switch_done = 0;
	power_type power_state;
	int mismatches = 0, total_checks = 0, cycles = 0, edges = 0, e0;
	watchdog_timer watchdog_timer_i (.*);
	always #5 pclk = ~pclk;
	always #43 rc_tick_async = ~rc_tick_async;
	always @(posedge rc_tick_async) edges++;
	always @(posedge pclk) if (++cycles == 40000) begin
		mismatches++;
		print_verdict();
	end
	task automatic print_verdict;
		if (mismatches == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : print_verdict
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task automatic wait_for(ref logic s, input int lim);
		for (int n = 0; s !== 1'b1 && n < lim; n++) @(posedge pclk);
	endtask : wait_for
	// enable just after a slow edge so the count starts from a known point
	task automatic start(logic [7:0] cfg);
		apb(1, 12'h000, {24'h0, cfg});
		apb(1, 12'h004, '0);
		@(posedge rc_tick_async);
		repeat (4) @(posedge pclk);
		apb(1, 12'h004, 32'h20);
		e0 = edges;
	endtask : start
	task automatic t_reset;
		apb(0, 12'h000, '0);
		chk("config", 32'hdf, rd);
		apb(0, 12'h004, '0);
		chk("soft", 0, rd[5]);
		apb(0, 12'h008, '0);
		chk("enabled", 1, rd[2]);
		chk("osc", 1, low_power_rc_osc_en);
		apb(1, 12'h020, 32'h1);
		chk("slverr", 1, err);
		apb(1, 12'h010, 32'h1);
	endtask : t_reset
	task automatic t_enable;
		apb(1, 12'h000, 32'h4f);
		apb(0, 12'h008, '0);
		chk("off", 0, rd[2]);
		apb(1, 12'h004, 32'h20);
		apb(0, 12'h008, '0);
		chk("on", 1, rd[2]);
		apb(1, 12'h000, 32'hcf);
		apb(1, 12'h004, '0);
		apb(0, 12'h008, '0);
		chk("forced", 1, rd[2]);
	endtask : t_enable
	task automatic t_period(logic [7:0] cfg, int exp);
		start(cfg);
		wait_for(watchdog_reset, 3000);
		chk("period", exp, edges - e0);
		apb(0, 12'h004, '0);
		chk("flag", 1, rd[4]);
		chk("irq", 1, irq);
		apb(0, 12'h00c, '0);
		chk("irq_status", 1, rd[0]);
		apb(1, 12'h004, '0);
		chk("irq_clear", 0, irq);
		apb(0, 12'h004, '0);
		chk("flag_clear", 0, rd[4]);
	endtask : t_period
	task automatic t_window(logic [7:0] cfg, int k, logic exp);
		start(cfg);
		while (edges - e0 < k) @(posedge pclk);
		repeat (5) @(posedge pclk);
		clear_watchdog_instr <= 1;
		@(posedge pclk);
		clear_watchdog_instr <= 0;
		e0 = edges;
		wait_for(watchdog_reset, 40);
		chk("early", exp, watchdog_reset);
		if (!exp) begin
			wait_for(watchdog_reset, 3000);
			chk("restart", 64, edges - e0);
		end
	endtask : t_window
	task automatic t_sleep(logic idle);
		apb(1, 12'h010, '0);
		start(8'h40);
		power_save_idle <= idle;
		power_save_instr <= 1;
		@(posedge pclk);
		power_save_instr <= 0;
		e0 = edges;
		apb(0, 12'h008, '0);
		chk("state", idle ? idle_mode : sleep_mode, rd[1:0]);
		wait_for(wake_core, 3000);
		chk("wake", 32, edges - e0);
		apb(0, 12'h004, '0);
		chk("save_bit", 1, idle ? rd[2] : rd[3]);
		chk("masked", 0, irq);
		apb(1, 12'h004, '0);
	endtask : t_sleep
	task automatic t_switch;
		start(8'h40);
		while (edges - e0 < 20) @(posedge pclk);
		repeat (5) @(posedge pclk);
		clock_switch_done <= 1;
		@(posedge pclk);
		clock_switch_done <= 0;
		e0 = edges;
		wait_for(watchdog_reset, 3000);
		chk("switch_restart", 32, edges - e0);
		apb(1, 12'h004, '0);
	endtask : t_switch
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1;
		t_reset();
		t_enable();
		t_period(8'h40, 32);
		t_period(8'h41, 64);
		t_period(8'h50, 128);
		t_window(8'h01, 8, 1);
		t_window(8'h41, 8, 0);
		t_window(8'h01, 56, 0);
		t_window(8'h01, 40, 1);
		t_switch();
		t_sleep(0);
		t_sleep(1);
		print_verdict();
	end
endmodule : test_watchdog_timer_window_mode

// ===== tb/wdt_monitor.sv
// port assertions for the watchdog timer
// assumes a bind onto watchdog_timer with pclk in one domain
`timescale 1ns/1ns
module wdt_monitor
	import wdt_pkg::*;
(
	input wire logic      pclk,
	input wire logic      presetn,
	input wire logic      clk_en,
	input wire logic      psel,
	input wire logic      penable,
	input wire logic      pready,
	input wire logic      pslverr,
	input wire logic      watchdog_reset,
	input wire logic      wake_core,
	input wire logic      low_power_rc_osc_en,
	input wire power_type power_state
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_after_setup: assert property (psel && !penable && clk_en |=> pready)
		else $error("no ready after setup");
	a_ready_one_shot: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_error_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_reset_ten_long: assert property ($rose(watchdog_reset) |->
		watchdog_reset[*8] ##3 !watchdog_reset) else $error("reset pulse length");
	a_reset_only_run: assert property ($rose(watchdog_reset) |-> power_state == run_mode)
		else $error("reset raised while saving power");
	a_wake_one_cycle: assert property (wake_core |=> !wake_core)
		else $error("wake pulse too long");
	a_wake_from_save: assert property (wake_core |-> $past(power_state) != run_mode)
		else $error("wake while running");
	a_wake_resumes_run: assert property (wake_core |-> ##[0:2] power_state == run_mode)
		else $error("no return to run");
	a_osc_after_reset: assert property ($rose(presetn) |-> ##[0:2] low_power_rc_osc_en)
		else $error("oscillator off after reset");
	c_reset: cover property ($rose(watchdog_reset));
	c_wake: cover property (wake_core);
	c_error: cover property (pslverr);
endmodule : wdt_monitor
bind watchdog_timer wdt_monitor wdt_monitor_i (.*);
